// ===== core/efs_map.vh
// Address map, field positions, reset values and timing counts of the frame statistics block
`ifndef EFS_MAP_VH
`define EFS_MAP_VH
`define EFS_NUM_CNT        20
`define EFS_CNT_RX_OVERSZ  0
`define EFS_CNT_RX_JABBER  1
`define EFS_CNT_RX_UNDERSZ 2
`define EFS_CNT_RX_FRAG    3
`define EFS_CNT_RX_FILT    4
`define EFS_CNT_RX_QOS     5
`define EFS_CNT_RX_BYTES   6
`define EFS_CNT_TX_GOOD    7
`define EFS_CNT_TX_BCAST   8
`define EFS_CNT_TX_MCAST   9
`define EFS_CNT_TX_PAUSE   10
`define EFS_CNT_TX_DEFER   11
`define EFS_CNT_TX_COLL    12
`define EFS_CNT_TX_ONE     13
`define EFS_CNT_TX_SEVERAL 14
`define EFS_CNT_TX_EXCESS  15
`define EFS_CNT_TX_LATE    16
`define EFS_CNT_TX_UNDERRUN 17
`define EFS_CNT_TX_CARRIER 18
`define EFS_CNT_FRAME64    19
`define EFS_ADDR_CTRL      8'h80
`define EFS_ADDR_MAXLEN    8'h84
`define EFS_CTRL_GIG_BIT   0
`define EFS_CTRL_QOS_BIT   1
`define EFS_CTRL_IEN_BIT   2
`define EFS_CTRL_W         3
`define EFS_CTRL_RST       3'h0
`define EFS_MAXLEN_RST     16'h05ee
`define EFS_MIN_FRAME      16'h0040
`define EFS_LATE_BITS      16'h0200
`define EFS_MAX_COLL       5'h10
`define EFS_MULTI_MIN      5'h02
`define EFS_MULTI_MAX      5'h0f
`define EFS_CLR_DELAY      6'h26
`define EFS_HALF_BIT       31
`define EFS_MCAST_BIT      40
`define EFS_BCAST_ADDR     48'hffff_ffff_ffff
`define EFS_ZERO32         32'h0000_0000
`define EFS_ONE32          32'h0000_0001
`define EFS_TWO32          32'h0000_0002
`define EFS_CNT_STRIDE     4
`endif

// ===== core/efs_stats.v
// Ethernet frame statistics counters with register port
`timescale 1ns/1ns
`include "efs_map.vh"
module efs_stats (
	input  wire        clk_sys_i,
	input  wire        sys_rst_i,
	input  wire        ce_i,
	input  wire [7:0]  addr_i,
	input  wire [31:0] wr_data_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rd_data_o,
	output reg         stats_interrupt_pending_o,
	input  wire        rx_end_i,
	input  wire [15:0] rx_len_i,
	input  wire        rx_addr_match_i,
	input  wire        rx_control_i,
	input  wire        rx_crc_err_i,
	input  wire        rx_align_err_i,
	input  wire        rx_code_err_i,
	input  wire        rx_coll_flow_i,
	input  wire [15:0] rx_channel_flow_threshold_i,
	input  wire [15:0] rx_channel_free_buffer_count_i,
	input  wire        rx_start_i,
	input  wire        half_duplex_i,
	input  wire        flow_active_i,
	input  wire        tx_coll_i,
	input  wire [15:0] tx_coll_bit_pos_i,
	input  wire        tx_end_i,
	input  wire [15:0] tx_len_i,
	input  wire [47:0] tx_dest_i,
	input  wire        tx_hw_pause_i,
	input  wire        tx_deferred_i,
	input  wire        tx_carrier_lost_i,
	input  wire        tx_underrun_i,
	output reg         tx_abort_o
);

	// Saturating subtract or direct load for a software write
	function [31:0] efs_wr_val;
		input [31:0] cur;
		input [31:0] val;
		input        gig;
		begin
			if (!gig) begin
				efs_wr_val = val;
			end else if (val > cur) begin
				efs_wr_val = `EFS_ZERO32;
			end else begin
				efs_wr_val = cur - val;
			end
		end
	endfunction

	// Length between 64 bytes and the maximum, inclusive
	function efs_len_ok;
		input [15:0] len;
		input [15:0] maxlen;
		begin
			efs_len_ok = (len >= `EFS_MIN_FRAME) && (len <= maxlen);
		end
	endfunction

	reg  [31:0]            cnt_q [0:`EFS_NUM_CNT-1];
	reg  [`EFS_CTRL_W-1:0] ctrl_q;
	reg  [15:0]            maxlen_q;
	reg  [5:0]             clr_cnt_q;
	reg                    clr_q;
	reg  [4:0]             coll_tally_q;
	reg                    late_q;
	reg                    aborted_q;
	reg  [32*`EFS_NUM_CNT-1:0] inc_d;
	wire [`EFS_NUM_CNT-1:0]    half_w;
	wire [32*`EFS_NUM_CNT-1:0] base_d;
	integer                    j;
	wire                   gig_w;
	wire                   rx_err_w;
	wire                   rx_long_w;
	wire                   rx_short_w;
	wire                   rx_good_w;
	wire                   tx_clean_w;
	wire                   tx_good_w;
	wire                   tx_bcast_w;
	wire                   tx_mcast_w;
	wire                   coll_late_w;
	wire                   coll_count_w;
	wire                   rx_coll_w;
	wire                   excess_now_w;
	wire                   excess_frame_w;
	wire [4:0]             tally_next_w;
	integer                k;

	assign gig_w      = ctrl_q[`EFS_CTRL_GIG_BIT];
	assign rx_err_w   = rx_crc_err_i | rx_align_err_i | rx_code_err_i;
	assign rx_long_w  = rx_len_i > maxlen_q;
	assign rx_short_w = rx_len_i < `EFS_MIN_FRAME;
	assign rx_good_w  = rx_addr_match_i & ~rx_err_w & efs_len_ok(rx_len_i, maxlen_q);

	assign coll_late_w  = tx_coll_bit_pos_i > `EFS_LATE_BITS;
	assign tally_next_w = coll_tally_q + 5'h01;
	assign excess_now_w = tx_coll_i & ~coll_late_w & ~late_q &
		(tally_next_w == `EFS_MAX_COLL);
	assign coll_count_w = tx_coll_i & ~tx_carrier_lost_i & ~tx_underrun_i;
	assign rx_coll_w    = rx_start_i & half_duplex_i & flow_active_i;

	assign tx_clean_w     = ~tx_carrier_lost_i & ~tx_underrun_i;
	assign excess_frame_w = (coll_tally_q == `EFS_MAX_COLL) & ~late_q;
	assign tx_good_w      = tx_end_i & tx_clean_w & ~late_q & ~excess_frame_w;
	assign tx_bcast_w     = tx_dest_i == `EFS_BCAST_ADDR;
	assign tx_mcast_w     = (tx_dest_i[`EFS_MCAST_BIT] & ~tx_bcast_w) | tx_hw_pause_i;

	// Per-counter increments; each counter has its own adder, but FRAME64 gains only one when a receive and a transmit 64-byte frame end in the same cycle
	always @* begin
		inc_d = {32*`EFS_NUM_CNT{1'b0}};
		if (rx_end_i) begin
			inc_d[32*`EFS_CNT_RX_OVERSZ +: 32] =
				{31'h0000_0000, rx_addr_match_i & rx_long_w & ~rx_err_w};
			inc_d[32*`EFS_CNT_RX_JABBER +: 32] =
				{31'h0000_0000, rx_addr_match_i & rx_long_w & rx_err_w};
			inc_d[32*`EFS_CNT_RX_UNDERSZ +: 32] =
				{31'h0000_0000, rx_addr_match_i & ~rx_control_i & rx_short_w & ~rx_err_w};
			inc_d[32*`EFS_CNT_RX_FRAG +: 32] =
				{31'h0000_0000, ~rx_control_i & rx_short_w & rx_err_w & ~rx_coll_flow_i};
			inc_d[32*`EFS_CNT_RX_FILT +: 32] =
				{31'h0000_0000, ~rx_control_i & ~rx_err_w & ~rx_addr_match_i};
			inc_d[32*`EFS_CNT_RX_QOS +: 32] =
				{31'h0000_0000, rx_good_w & ctrl_q[`EFS_CTRL_QOS_BIT] &
				(rx_channel_flow_threshold_i >= rx_channel_free_buffer_count_i)};
			if (rx_good_w) begin
				inc_d[32*`EFS_CNT_RX_BYTES +: 32] = {16'h0000, rx_len_i};
			end
			if (rx_addr_match_i && rx_len_i == `EFS_MIN_FRAME) begin
				inc_d[32*`EFS_CNT_FRAME64 +: 32] = `EFS_ONE32;
			end
		end
		if (coll_count_w && rx_coll_w) begin
			inc_d[32*`EFS_CNT_TX_COLL +: 32] = `EFS_TWO32;
		end else if (coll_count_w || rx_coll_w) begin
			inc_d[32*`EFS_CNT_TX_COLL +: 32] = `EFS_ONE32;
		end
		if (tx_end_i) begin
			inc_d[32*`EFS_CNT_TX_GOOD +: 32]  = {31'h0000_0000, tx_good_w};
			inc_d[32*`EFS_CNT_TX_BCAST +: 32] = {31'h0000_0000, tx_good_w & tx_bcast_w};
			inc_d[32*`EFS_CNT_TX_MCAST +: 32] = {31'h0000_0000, tx_good_w & tx_mcast_w};
			inc_d[32*`EFS_CNT_TX_PAUSE +: 32] = {31'h0000_0000, tx_hw_pause_i};
			inc_d[32*`EFS_CNT_TX_DEFER +: 32] =
				{31'h0000_0000, tx_good_w & tx_deferred_i & (coll_tally_q == 5'h00)};
			inc_d[32*`EFS_CNT_TX_ONE +: 32] =
				{31'h0000_0000, tx_good_w & (coll_tally_q == 5'h01)};
			inc_d[32*`EFS_CNT_TX_SEVERAL +: 32] = {31'h0000_0000, tx_good_w &
				(coll_tally_q >= `EFS_MULTI_MIN) & (coll_tally_q <= `EFS_MULTI_MAX)};
			inc_d[32*`EFS_CNT_TX_EXCESS +: 32] =
				{31'h0000_0000, tx_clean_w & excess_frame_w};
			inc_d[32*`EFS_CNT_TX_LATE +: 32]     = {31'h0000_0000, late_q};
			inc_d[32*`EFS_CNT_TX_UNDERRUN +: 32] = {31'h0000_0000, tx_underrun_i};
			inc_d[32*`EFS_CNT_TX_CARRIER +: 32]  = {31'h0000_0000, tx_carrier_lost_i};
			if ((tx_good_w && tx_len_i == `EFS_MIN_FRAME) || tx_hw_pause_i) begin
				inc_d[32*`EFS_CNT_FRAME64 +: 32] = `EFS_ONE32;
			end
		end
	end

	// Delayed clear after reset release
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			clr_cnt_q <= 6'h00;
			clr_q     <= 1'b0;
		end else if (ce_i) begin
			clr_q <= 1'b0;
			if (clr_cnt_q != `EFS_CLR_DELAY) begin
				clr_cnt_q <= clr_cnt_q + 6'h01;
				clr_q     <= (clr_cnt_q + 6'h01) == `EFS_CLR_DELAY;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `EFS_NUM_CNT; gi = gi + 1) begin : g_cnt
			wire hit_w;
			assign hit_w = wr_i && (addr_i == gi * `EFS_CNT_STRIDE);
			assign base_d[32*gi +: 32] = hit_w ?
				efs_wr_val(cnt_q[gi], wr_data_i, gig_w) : cnt_q[gi];
			assign half_w[gi] = cnt_q[gi][`EFS_HALF_BIT];
		end
	endgenerate

	// All counters in one process so the array has a single driver
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (j = 0; j < `EFS_NUM_CNT; j = j + 1) begin
				cnt_q[j] <= `EFS_ZERO32;
			end
		end else if (ce_i) begin
			for (j = 0; j < `EFS_NUM_CNT; j = j + 1) begin
				if (clr_q) begin
					cnt_q[j] <= `EFS_ZERO32;
				end else begin
					cnt_q[j] <= base_d[32*j +: 32] + inc_d[32*j +: 32];
				end
			end
		end
	end

	// Per-frame collision tally and abandon decisions
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			coll_tally_q <= 5'h00;
			late_q       <= 1'b0;
			aborted_q    <= 1'b0;
			tx_abort_o   <= 1'b0;
		end else if (ce_i) begin
			tx_abort_o <= 1'b0;
			if (tx_end_i) begin
				coll_tally_q <= 5'h00;
				late_q       <= 1'b0;
				aborted_q    <= 1'b0;
			end else if (!aborted_q) begin
				if (tx_coll_i && coll_late_w) begin
					late_q     <= 1'b1;
					aborted_q  <= 1'b1;
					tx_abort_o <= 1'b1;
				end else if (tx_coll_i) begin
					coll_tally_q <= tally_next_w;
					if (excess_now_w) begin
						aborted_q  <= 1'b1;
						tx_abort_o <= 1'b1;
					end
				end else if (tx_carrier_lost_i) begin
					aborted_q  <= 1'b1;
					tx_abort_o <= 1'b1;
				end
			end
		end
	end

	// Control registers and read port
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_q                    <= `EFS_CTRL_RST;
			maxlen_q                  <= `EFS_MAXLEN_RST;
			rd_data_o                 <= `EFS_ZERO32;
			stats_interrupt_pending_o <= 1'b0;
		end else if (ce_i) begin
			if (wr_i && addr_i == `EFS_ADDR_CTRL) begin
				ctrl_q <= wr_data_i[`EFS_CTRL_W-1:0];
			end
			if (wr_i && addr_i == `EFS_ADDR_MAXLEN) begin
				maxlen_q <= wr_data_i[15:0];
			end
			stats_interrupt_pending_o <= ctrl_q[`EFS_CTRL_IEN_BIT] & (|half_w);
			rd_data_o <= `EFS_ZERO32;
			if (rd_i) begin
				if (addr_i == `EFS_ADDR_CTRL) begin
					rd_data_o <= {29'h0000_0000, ctrl_q};
				end else if (addr_i == `EFS_ADDR_MAXLEN) begin
					rd_data_o <= {16'h0000, maxlen_q};
				end else begin
					for (k = 0; k < `EFS_NUM_CNT; k = k + 1) begin
						if (addr_i == k * `EFS_CNT_STRIDE) begin
							rd_data_o <= cnt_q[k];
						end
					end
				end
			end
		end
	end

endmodule // efs_stats

// ===== dv/efs_mac_model.sv
// Frame engine model giving per-frame receive and transmit status
`timescale 1ns/1ns
module efs_mac_model (
	input  wire        clk_sys_i,
	output reg  [3:0]  ev_o = 4'h0,
	output reg  [15:0] len_o = 16'h0000,
	output reg  [47:0] dest_o = 48'h0000_0000_0000,
	output reg  [11:0] fl_o = 12'h000
);
	// One status pulse; qualifiers change once the pulse is over
	task ev(input [3:0] e, input [15:0] l, input [11:0] f, input [47:0] d);
		@(posedge clk_sys_i);
		ev_o <= e;
		len_o <= l;
		fl_o <= f;
		dest_o <= d;
		@(posedge clk_sys_i);
		ev_o <= 4'h0;
		len_o <= ~l;
		fl_o <= 12'h000;
		dest_o <= ~d;
	endtask
endmodule // efs_mac_model

// ===== dv/efs_stats_props.sv
// Checker on the frame statistics ports
`timescale 1ns/1ns
module efs_stats_props (
	input wire        clk_sys_i,
	input wire        sys_rst_i,
	input wire [7:0]  addr_i,
	input wire [31:0] wr_data_i,
	input wire        wr_i,
	input wire        rd_i,
	input wire [31:0] rd_data_o,
	input wire        stats_interrupt_pending_o,
	input wire        tx_coll_i,
	input wire [15:0] tx_coll_bit_pos_i,
	input wire        tx_end_i,
	input wire        tx_carrier_lost_i,
	input wire        tx_underrun_i,
	input wire        tx_abort_o
);
	reg  [4:0] n_q;
	reg        ab_q;
	wire       late = tx_coll_bit_pos_i > 16'h0200;
	wire       ok   = !tx_carrier_lost_i && !tx_underrun_i && !ab_q;
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	// Non-late collisions of the frame in flight, frozen once it is abandoned
	always @(posedge clk_sys_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			n_q <= 5'h00;
			ab_q <= 1'b0;
		end else if (tx_end_i) begin
			n_q <= 5'h00;
			ab_q <= 1'b0;
		end else begin
			if (tx_coll_i && !late && !ab_q)
				n_q <= n_q + 5'h01;
			if (tx_abort_o)
				ab_q <= 1'b1;
		end
	end
	sequence s_late;
		tx_coll_i && late && !ab_q;
	endsequence
	sequence s_early;
		tx_coll_i && !late && ok;
	endsequence
	property p_late; s_late |=> tx_abort_o; endproperty
	a_late: assert property (p_late) else $error("late collision not abandoned");
	property p_excess; s_early ##0 (n_q == 5'h0f) |=> tx_abort_o; endproperty
	a_excess: assert property (p_excess) else $error("16th collision not abandoned");
	property p_keep; s_early ##0 (n_q < 5'h0f) |=> !tx_abort_o; endproperty
	a_keep: assert property (p_keep) else $error("frame abandoned too early");
	property p_pulse; tx_abort_o |=> !tx_abort_o; endproperty
	a_pulse: assert property (p_pulse) else $error("abort longer than one cycle");
	property p_carrier;
		!tx_end_i && !tx_coll_i && tx_carrier_lost_i && !ab_q |=> tx_abort_o;
	endproperty
	a_carrier: assert property (p_carrier) else $error("carrier loss retried");
	property p_cause; tx_abort_o |-> $past(tx_coll_i || tx_carrier_lost_i); endproperty
	a_cause: assert property (p_cause) else $error("abort without cause");
	property p_irq_off;
		wr_i && addr_i == 8'h80 && !wr_data_i[2] |=> ##1 !stats_interrupt_pending_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("masked interrupt raised");
	property p_rd_idle; !rd_i |=> rd_data_o == 32'h0000_0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // efs_stats_props
bind efs_stats efs_stats_props u_props (
	.clk_sys_i, .sys_rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
	.stats_interrupt_pending_o, .tx_coll_i, .tx_coll_bit_pos_i, .tx_end_i,
	.tx_carrier_lost_i, .tx_underrun_i, .tx_abort_o);

// ===== dv/efs_stats_test.sv
// Self-checking bench for the frame statistics counters
`timescale 1ns/1ns
module efs_stats_test;
	localparam [47:0] uni = 48'h0000_1111_2222;
	localparam [31:0] exp_cnt [0:19] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001,
		32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_00e4, 32'h0000_0008,
		32'h0000_0001, 32'h0000_0003, 32'h0000_0001, 32'h0000_0001, 32'h0000_0025,
		32'h0000_0001, 32'h0000_0002, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001,
		32'h0000_0001, 32'h0000_0004};
	reg         clk_sys_i = 1'b0;
	reg         sys_rst_i = 1'b1;
	reg  [7:0]  addr_i    = 8'h00;
	reg  [31:0] wr_data_i = 32'h0000_0000;
	reg         wr_i      = 1'b0;
	reg         rd_i      = 1'b0;
	wire [31:0] rd_data_o;
	wire        irq_o;
	wire        tx_abort_o;
	wire [3:0]  ev;
	wire [15:0] len;
	wire [47:0] dest;
	wire [11:0] fl;
	integer     num_errors = 0;
	integer     num_checks = 0;
	integer     i;
	always #20 clk_sys_i = ~clk_sys_i;
	efs_mac_model m (.clk_sys_i, .ev_o(ev), .len_o(len), .dest_o(dest), .fl_o(fl));
	efs_stats dut (.clk_sys_i, .sys_rst_i, .ce_i(1'b1), .addr_i, .wr_data_i, .wr_i, .rd_i,
		.rd_data_o, .stats_interrupt_pending_o(irq_o), .rx_end_i(ev[3]), .rx_len_i(len),
		.rx_addr_match_i(fl[11]), .rx_control_i(fl[10]), .rx_crc_err_i(fl[9]),
		.rx_align_err_i(fl[8]), .rx_code_err_i(fl[7]), .rx_coll_flow_i(fl[6]),
		.rx_channel_flow_threshold_i(dest[15:0]), .rx_channel_free_buffer_count_i(16'h0005),
		.rx_start_i(ev[2]), .half_duplex_i(fl[5]), .flow_active_i(fl[4]), .tx_coll_i(ev[1]),
		.tx_coll_bit_pos_i(len), .tx_end_i(ev[0]), .tx_len_i(len), .tx_dest_i(dest),
		.tx_hw_pause_i(fl[3]), .tx_deferred_i(fl[2]), .tx_carrier_lost_i(fl[1]),
		.tx_underrun_i(fl[0]), .tx_abort_o);
	task chk(input string nm, input [31:0] s, input [31:0] x);
		num_checks = num_checks + 1;
		if (s !== x) begin
			num_errors = num_errors + 1;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		@(posedge clk_sys_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wr_data_i <= d;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	task rd(input [7:0] a, input [31:0] x);
		@(posedge clk_sys_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1 chk($sformatf("reg %h", a), rd_data_o, x);
	endtask
	task sweep(input integer lo, input integer hi, input z);
		for (i = lo; i <= hi; i = i + 1)
			rd(8'(i * 4), z ? 32'h0000_0000 : exp_cnt[i]);
	endtask
	// Collisions at fixed positions, the last one at p, then the frame end
	task cfr(input [4:0] n, input [15:0] p);
		for (i = 1; i < n; i = i + 1)
			m.ev(4'h2, 16'h0064, 12'h000, 48'h0);
		m.ev(4'h2, p, 12'h000, 48'h0);
		m.ev(4'h1, 16'h0064, 12'h000, uni);
	endtask
	task irq(input x);
		repeat (2) @(posedge clk_sys_i);
		#1 chk("irq", {31'h0000_0000, irq_o}, {31'h0000_0000, x});
	endtask
	task print_verdict;
		if (num_errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		wr(8'h00, 32'h0000_0007);
		repeat (40) @(posedge clk_sys_i);
		sweep(0, 19, 1'b1);
		rd(8'h84, 32'h0000_05ee);
		rd(8'h90, 32'h0000_0000);
		wr(8'h84, 32'h0000_0064);
		m.ev(4'h8, 16'h0065, 12'h800, 48'h0);
		m.ev(4'h8, 16'h0065, 12'ha00, 48'h0);
		m.ev(4'h8, 16'h003f, 12'h800, 48'h0);
		m.ev(4'h8, 16'h003f, 12'hc00, 48'h0);
		m.ev(4'h8, 16'h003f, 12'h100, 48'h0);
		m.ev(4'h8, 16'h003f, 12'h8c0, 48'h0);
		m.ev(4'h8, 16'h0050, 12'h000, 48'h0);
		m.ev(4'h8, 16'h0050, 12'h400, 48'h0);
		m.ev(4'h8, 16'h0064, 12'h800, 48'h0);
		wr(8'h80, 32'h0000_0002);
		m.ev(4'h8, 16'h0040, 12'h800, 48'h5);
		m.ev(4'h8, 16'h0040, 12'h800, 48'h4);
		m.ev(4'h8, 16'h0040, 12'ha00, 48'h0);
		m.ev(4'h4, 16'h0000, 12'h030, 48'h0);
		m.ev(4'h4, 16'h0000, 12'h020, 48'h0);
		sweep(0, 6, 1'b0);
		m.ev(4'h1, 16'h00c8, 12'h004, uni);
		m.ev(4'h1, 16'h0064, 12'h000, 48'hffff_ffff_ffff);
		m.ev(4'h1, 16'h0064, 12'h000, 48'h0100_5e00_0001);
		m.ev(4'h1, 16'h0040, 12'h008, 48'h0180_c200_0001);
		m.ev(4'h1, 16'h0064, 12'h000, 48'h0180_c200_0001);
		cfr(1, 16'h0200);
		cfr(2, 16'h0064);
		cfr(15, 16'h0064);
		cfr(16, 16'h0064);
		cfr(2, 16'h0258);
		m.ev(4'h1, 16'h0064, 12'h001, uni);
		m.ev(4'h0, 16'h0064, 12'h002, uni);
		m.ev(4'h1, 16'h0064, 12'h002, uni);
		sweep(7, 12, 1'b0);
		sweep(13, 19, 1'b0);
		wr(8'h00, 32'h0000_0005);
		rd(8'h00, 32'h0000_0005);
		wr(8'h80, 32'h0000_0005);
		wr(8'h00, 32'h0000_0002);
		rd(8'h00, 32'h0000_0003);
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h0000_0000);
		wr(8'h80, 32'h0000_0004);
		wr(8'h00, 32'hffff_ffff);
		irq(1'b1);
		wr(8'h80, 32'h0000_0005);
		wr(8'h00, 32'h8000_0000);
		irq(1'b0);
		wr(8'h80, 32'h0000_0000);
		wr(8'h00, 32'hffff_ffff);
		irq(1'b0);
		m.ev(4'h8, 16'h0065, 12'h800, 48'h0);
		rd(8'h00, 32'h0000_0000);
		print_verdict;
	end
endmodule // efs_stats_test
